// >>> rtl/adc_config_register_bank.sv
// configuration register bank and derived controls of the converter
// Contract
// [R1] format field: 00 follows format pin, 10 twos complement, 11 offset binary
// [R2] dc correction loop runs only while correction bit is one
// [R3] user test word is high register plus upper nibble of low register
// [R4] interface field: 00/10 follow pin, 01 DDR LVDS, 11 parallel CMOS
// [R5] CMOS mode sets clock drive strength from two-bit field
// [R6] rise edge code applies only while rise enable is one
// [R7] LVDS rise codes: default, 500 ps, aligned, 200 ps
// [R8] CMOS rise codes: default, 100 ps, 200 ps, 1.5 ns
// [R9] fall edge code applies only while fall enable is one
// [R10] fall edge positioned by two-bit code in either interface
// [R11] digital path bit zero bypasses gain, patterns and correction
// [R12] light sleep powers down converter and buffers, reference stays on
// [R13] full sleep powers down converter, references and buffers
// [R14] driver off powers down output pins into high impedance
// [R15] swing setting honoured only when swing enable is 11
// [R16] controller sets high frequency bit above 230 MHz input
// [R17] corrected output converges on mid-code
// [R18] signed four-bit pedestal added to converged value
// [R19] hold freezes estimate and reuses last value
// [R20] loop time constant is one million cycles doubled per code step
// [R21] low speed mode only when field is 11
// [R22] data strength bit selects 100-ohm or 50-ohm termination
// [R23] readback mode blocks writes except to address zero
// [R24] test pattern code 101 outputs the user test word
`timescale 1ns/1ps
module adc_config_register_bank
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rdata_valid_o,
  input wire logic format_select_pin_i,
  input wire logic [2:0] test_pattern_sel_i,
  output logic readback_mode_o,
  output logic twos_complement_o,
  output logic lvds_mode_o,
  output logic cmos_mode_o,
  output logic dc_correction_on_o,
  output logic estimate_hold_o,
  output logic [3:0] loop_averaging_code_o,
  output logic [31:0] loop_time_constant_o,
  output logic [11:0] correction_target_o,
  output logic [11:0] user_test_word_o,
  output logic user_pattern_active_o,
  output logic digital_path_enable_o,
  output logic [1:0] parallel_clock_drive_o,
  output logic [1:0] rise_shift_code_o,
  output logic [1:0] fall_shift_code_o,
  output logic converter_off_o,
  output logic reference_off_o,
  output logic output_driver_off_o,
  output logic swing_control_on_o,
  output logic high_freq_tuning_bit_o,
  output logic slow_rate_mode_o,
  output logic double_data_strength_o
);
  import adc_cfg_pkg::*;

  logic [7:0] mode_ctrl, data_strength, format, test_high, test_low;
  logic [7:0] iface_rise, fall_lat, power, hf_tune, pedestal, loop_ctrl, slow_rate;
  logic fmt_pin_q1, fmt_pin_q2;

  // format pin is asynchronous, two flops before use
  always_ff @(posedge clk_i)
  begin
    fmt_pin_q1 <= format_select_pin_i;
    fmt_pin_q2 <= fmt_pin_q1;
  end

  wire readback = mode_ctrl[READBACK_BIT];
  // only address zero stays writable in readback mode
  wire wr_ok = wr_en_i && (!readback || addr_i == ADDR_MODE_CTRL); // [R23]
  wire soft_reset = wr_en_i && addr_i == ADDR_MODE_CTRL && wdata_i[SOFT_RESET_BIT];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || soft_reset)
    begin
      mode_ctrl <= RESET_VALUE;
      data_strength <= RESET_VALUE;
      format <= RESET_VALUE;
      test_high <= RESET_VALUE;
      test_low <= RESET_VALUE;
      iface_rise <= RESET_VALUE;
      fall_lat <= RESET_VALUE;
      power <= RESET_VALUE;
      hf_tune <= RESET_VALUE;
      pedestal <= RESET_VALUE;
      loop_ctrl <= RESET_VALUE;
      slow_rate <= RESET_VALUE;
    end
    else if (wr_ok)
    begin
      // reset bit self-clears, so only readback is stored
      if (hit(addr_i, ADDR_MODE_CTRL)) mode_ctrl <= {7'h00, wdata_i[READBACK_BIT]};
      if (hit(addr_i, ADDR_DATA_STRENGTH)) data_strength <= {6'h00, wdata_i[1:0]};
      if (hit(addr_i, ADDR_FORMAT)) format <= {wdata_i[7:5], 5'h00};
      if (hit(addr_i, ADDR_TEST_HIGH)) test_high <= wdata_i;
      if (hit(addr_i, ADDR_TEST_LOW)) test_low <= {wdata_i[7:4], 4'h0};
      if (hit(addr_i, ADDR_IFACE_RISE)) iface_rise <= wdata_i;
      if (hit(addr_i, ADDR_FALL_LAT)) fall_lat <= {wdata_i[7:6], 2'b00, wdata_i[3:2], 2'b00};
      if (hit(addr_i, ADDR_POWER)) power <= {1'b0, wdata_i[6], 1'b0, wdata_i[4], 2'b00,
                                             wdata_i[1:0]};
      if (hit(addr_i, ADDR_HF_TUNE)) hf_tune <= {7'h00, wdata_i[0]};
      if (hit(addr_i, ADDR_PEDESTAL)) pedestal <= {wdata_i[7:4], 4'h0};
      if (hit(addr_i, ADDR_LOOP_CTRL)) loop_ctrl <= {wdata_i[7], 1'b0, wdata_i[5:2], 2'b00};
      if (hit(addr_i, ADDR_SLOW_RATE)) slow_rate <= {2'b00, wdata_i[5:4], 4'h0};
    end
  end

  // readback: address zero itself cannot be read, returns zero
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (addr_i)
      ADDR_DATA_STRENGTH: next_rdata = data_strength;
      ADDR_FORMAT: next_rdata = format;
      ADDR_TEST_HIGH: next_rdata = test_high;
      ADDR_TEST_LOW: next_rdata = test_low;
      ADDR_IFACE_RISE: next_rdata = iface_rise;
      ADDR_FALL_LAT: next_rdata = fall_lat;
      ADDR_POWER: next_rdata = power;
      ADDR_HF_TUNE: next_rdata = hf_tune;
      ADDR_PEDESTAL: next_rdata = pedestal;
      ADDR_LOOP_CTRL: next_rdata = loop_ctrl;
      ADDR_SLOW_RATE: next_rdata = slow_rate;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      rdata_o <= 8'h00;
      rdata_valid_o <= 1'b0;
    end
    else
    begin
      rdata_valid_o <= rd_en_i && readback;
      if (rd_en_i && readback) rdata_o <= next_rdata;
    end
  end

  // field decode
  wire [1:0] fmt_code = format[FORMAT_LSB +: 2];
  wire [1:0] if_code = iface_rise[IFACE_LSB +: 2];
  wire [1:0] rise_code = iface_rise[RISE_CODE_LSB +: 2];
  wire [1:0] fall_code = fall_lat[FALL_CODE_LSB +: 2];
  wire [3:0] ped = pedestal[PEDESTAL_LSB +: 4];
  wire [3:0] avg = loop_ctrl[AVG_CODE_LSB +: 4];
  // pin-controlled modes: pin high picks twos complement and CMOS
  wire pin_level = fmt_pin_q2;
  wire fmt_twos = (fmt_code == FMT_TWOS) ? 1'b1 :
                  (fmt_code == FMT_OFFSET) ? 1'b0 : pin_level; // [R1]
  wire if_cmos = (if_code == IF_CMOS) ? 1'b1 :
                 (if_code == IF_LVDS) ? 1'b0 : pin_level; // [R4]
  wire dig_en = fall_lat[DIGITAL_EN_BIT];
  wire corr_on = format[CORR_ON_BIT] && dig_en; // [R2] [R11]

  assign readback_mode_o = readback;
  assign twos_complement_o = fmt_twos;
  assign lvds_mode_o = !if_cmos;
  assign cmos_mode_o = if_cmos;
  assign dc_correction_on_o = corr_on; // [R2]
  assign estimate_hold_o = corr_on && loop_ctrl[HOLD_BIT]; // [R19]
  // codes above 1011 are undefined, clamped to the longest constant
  assign loop_averaging_code_o = (avg > AVG_CODE_MAX) ? AVG_CODE_MAX : avg; // [R20]
  assign loop_time_constant_o = 32'h0010_0000 << loop_averaging_code_o; // [R20]
  // mid-code plus sign-extended pedestal
  assign correction_target_o = MID_CODE + {{8{ped[3]}}, ped}; // [R17] [R18]
  assign user_test_word_o = {test_high, test_low[7:4]}; // [R3]
  assign user_pattern_active_o = dig_en && test_pattern_sel_i == PATTERN_USER; // [R24] [R11]
  assign digital_path_enable_o = dig_en; // [R11]
  // drive only matters in CMOS; LVDS sees maximum
  assign parallel_clock_drive_o = if_cmos ? iface_rise[CLK_DRIVE_LSB +: 2] : 2'b00; // [R5]
  // code meaning (ps shift) depends on interface; analog decodes it
  assign rise_shift_code_o = iface_rise[RISE_EN_BIT] ? rise_code : EDGE_DEFAULT; // [R6] [R7] [R8]
  assign fall_shift_code_o = iface_rise[FALL_EN_BIT] ? fall_code : EDGE_DEFAULT; // [R9] [R10]
  assign converter_off_o = fall_lat[LIGHT_SLEEP_BIT] || power[FULL_SLEEP_BIT]; // [R12] [R13]
  assign reference_off_o = power[FULL_SLEEP_BIT]; // [R13]
  assign output_driver_off_o = power[DRIVER_OFF_BIT] || fall_lat[LIGHT_SLEEP_BIT]
                               || power[FULL_SLEEP_BIT]; // [R12] [R13] [R14]
  // 01 and 10 are forbidden writes; treated as off
  assign swing_control_on_o = power[SWING_EN_LSB +: 2] == BOTH_ON; // [R15]
  assign high_freq_tuning_bit_o = hf_tune[HF_TUNE_BIT]; // [R16]
  assign slow_rate_mode_o = slow_rate[SLOW_LSB +: 2] == BOTH_ON; // [R21]
  assign double_data_strength_o = data_strength[DATA_STRENGTH_BIT]; // [R22]

  a_readback_blocks: assert property (@(posedge clk_i) disable iff (!resetn_i)
    readback && wr_en_i && addr_i != ADDR_MODE_CTRL |=> $stable(format) && $stable(power))
    else $error("write accepted in readback mode"); // [R23]
  a_format_twos: assert property (@(posedge clk_i) disable iff (!resetn_i)
    fmt_code == FMT_TWOS |-> twos_complement_o) else $error("format not twos"); // [R1]
  a_format_offset: assert property (@(posedge clk_i) disable iff (!resetn_i)
    fmt_code == FMT_OFFSET |-> !twos_complement_o) else $error("format not offset"); // [R1]
  a_iface_select: assert property (@(posedge clk_i) disable iff (!resetn_i)
    if_code == IF_LVDS |-> lvds_mode_o && !cmos_mode_o) else $error("iface wrong"); // [R4]
  a_corr_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !format[CORR_ON_BIT] |-> !dc_correction_on_o && !estimate_hold_o)
    else $error("correction without enable"); // [R2]
  a_test_word: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_ok && addr_i == ADDR_TEST_HIGH && !soft_reset |=> user_test_word_o[11:4] == $past(wdata_i))
    else $error("test word high wrong"); // [R3]
  a_rise_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !iface_rise[RISE_EN_BIT] |-> rise_shift_code_o == EDGE_DEFAULT) else $error("rise shifted"); // [R6]
  a_fall_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !iface_rise[FALL_EN_BIT] |-> fall_shift_code_o == EDGE_DEFAULT) else $error("fall shifted"); // [R9]
  a_full_sleep: assert property (@(posedge clk_i) disable iff (!resetn_i)
    power[FULL_SLEEP_BIT] |-> converter_off_o && reference_off_o && output_driver_off_o)
    else $error("full sleep incomplete"); // [R13]
  a_light_sleep: assert property (@(posedge clk_i) disable iff (!resetn_i)
    fall_lat[LIGHT_SLEEP_BIT] && !power[FULL_SLEEP_BIT] |-> converter_off_o && !reference_off_o)
    else $error("light sleep wrong"); // [R12]
  a_swing_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    swing_control_on_o |-> power[1] && power[0]) else $error("swing on wrongly"); // [R15]
  a_ped_target: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ped == 4'b1000 |-> correction_target_o == MID_CODE - 12'd8) else $error("pedestal"); // [R18]
endmodule

// >>> rtl/adc_cfg_pkg.sv
// constants for the converter configuration register bank
package adc_cfg_pkg;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DATA_STRENGTH = 8'h26;
  localparam logic [7:0] ADDR_FORMAT = 8'h3d;
  localparam logic [7:0] ADDR_TEST_HIGH = 8'h3f;
  localparam logic [7:0] ADDR_TEST_LOW = 8'h40;
  localparam logic [7:0] ADDR_IFACE_RISE = 8'h41;
  localparam logic [7:0] ADDR_FALL_LAT = 8'h42;
  localparam logic [7:0] ADDR_POWER = 8'h43;
  localparam logic [7:0] ADDR_HF_TUNE = 8'h4a;
  localparam logic [7:0] ADDR_PEDESTAL = 8'hbf;
  localparam logic [7:0] ADDR_LOOP_CTRL = 8'hcf;
  localparam logic [7:0] ADDR_SLOW_RATE = 8'hdf;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam int READBACK_BIT = 0;
  localparam int SOFT_RESET_BIT = 1;
  localparam int DATA_STRENGTH_BIT = 0;
  localparam int FORMAT_LSB = 6;
  localparam int CORR_ON_BIT = 5;
  localparam int IFACE_LSB = 6;
  localparam int CLK_DRIVE_LSB = 4;
  localparam int RISE_EN_BIT = 3;
  localparam int RISE_CODE_LSB = 1;
  localparam int FALL_EN_BIT = 0;
  localparam int FALL_CODE_LSB = 6;
  localparam int DIGITAL_EN_BIT = 3;
  localparam int LIGHT_SLEEP_BIT = 2;
  localparam int FULL_SLEEP_BIT = 6;
  localparam int DRIVER_OFF_BIT = 4;
  localparam int SWING_EN_LSB = 0;
  localparam int HF_TUNE_BIT = 0;
  localparam int PEDESTAL_LSB = 4;
  localparam int HOLD_BIT = 7;
  localparam int AVG_CODE_LSB = 2;
  localparam int SLOW_LSB = 4;
  localparam logic [1:0] FMT_PIN = 2'b00;
  localparam logic [1:0] FMT_TWOS = 2'b10;
  localparam logic [1:0] FMT_OFFSET = 2'b11;
  localparam logic [1:0] IF_LVDS = 2'b01;
  localparam logic [1:0] IF_CMOS = 2'b11;
  localparam logic [1:0] BOTH_ON = 2'b11;
  localparam logic [1:0] EDGE_DEFAULT = 2'b00;
  localparam logic [2:0] PATTERN_USER = 3'b101;
  localparam logic [3:0] AVG_CODE_MAX = 4'b1011;
  localparam logic [11:0] MID_CODE = 12'h800;
endpackage

// >>> verif/cfg_controller_model.sv
// controller model that writes and reads the configuration registers
`timescale 1ns/1ps
module cfg_controller_model
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rdata_valid_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial
  begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // high freq bit and slow rate field are written as the caller gives them; only the power register 43 gets its swing enable bits forced
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == 8'h43) ? {d[7:2], {2{d[0]}}} : d; // swing enable never 01 or 10
    @(posedge clk_i);
    wr_en_o <= 1'b1;
    addr_o <= a;
    wdata_o <= v;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~v;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk_i);
    rd_en_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    repeat (3)
    begin
      #1;
      if (!ok && rdata_valid_i === 1'b1)
      begin
        ok = 1'b1;
        d = rdata_i;
      end
      @(posedge clk_i);
    end
  endtask
endmodule

// >>> verif/adc_config_register_bank_bench.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) \
  begin mismatches++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module adc_config_register_bank_bench;
  import adc_cfg_pkg::*;
  logic clk_i, resetn_i, wr_en_i, rd_en_i, rdata_valid_o, pin, readback_mode_o;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic [2:0] tps;
  logic twos_complement_o, lvds_mode_o, cmos_mode_o, dc_correction_on_o, estimate_hold_o;
  logic [3:0] loop_averaging_code_o;
  logic [31:0] loop_time_constant_o;
  logic [11:0] correction_target_o, user_test_word_o;
  logic user_pattern_active_o, digital_path_enable_o, converter_off_o, reference_off_o;
  logic [1:0] parallel_clock_drive_o, rise_shift_code_o, fall_shift_code_o;
  logic output_driver_off_o, swing_control_on_o, high_freq_tuning_bit_o;
  logic slow_rate_mode_o, double_data_strength_o;
  logic [7:0] rm [0:255];
  logic [7:0] al [12] = '{8'h26, 8'h3d, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h43, 8'h4a, 8'hbf,
    8'hcf, 8'hdf, 8'h77};
  int mismatches = 0;
  int samples_checked = 0;
  int seed = 41;
  adc_config_register_bank u_adc_config_register_bank (.clk_i(clk_i), .resetn_i(resetn_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .format_select_pin_i(pin),
    .test_pattern_sel_i(tps), .readback_mode_o(readback_mode_o),
    .twos_complement_o(twos_complement_o), .lvds_mode_o(lvds_mode_o),
    .cmos_mode_o(cmos_mode_o), .dc_correction_on_o(dc_correction_on_o),
    .estimate_hold_o(estimate_hold_o), .loop_averaging_code_o(loop_averaging_code_o),
    .loop_time_constant_o(loop_time_constant_o), .correction_target_o(correction_target_o),
    .user_test_word_o(user_test_word_o), .user_pattern_active_o(user_pattern_active_o),
    .digital_path_enable_o(digital_path_enable_o),
    .parallel_clock_drive_o(parallel_clock_drive_o), .rise_shift_code_o(rise_shift_code_o),
    .fall_shift_code_o(fall_shift_code_o), .converter_off_o(converter_off_o),
    .reference_off_o(reference_off_o), .output_driver_off_o(output_driver_off_o),
    .swing_control_on_o(swing_control_on_o), .high_freq_tuning_bit_o(high_freq_tuning_bit_o),
    .slow_rate_mode_o(slow_rate_mode_o), .double_data_strength_o(double_data_strength_o));
  cfg_controller_model u_cfg_controller_model (.clk_i(clk_i), .rdata_i(rdata_o),
    .rdata_valid_i(rdata_valid_o), .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i),
    .wdata_o(wdata_i));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  function automatic logic [7:0] keep(input logic [7:0] a);
    case (a)
      8'h00, 8'h4a: keep = 8'h01;
      8'h26: keep = 8'h03;
      8'h3d: keep = 8'he0;
      8'h3f, 8'h41: keep = 8'hff;
      8'h40, 8'hbf: keep = 8'hf0;
      8'h42: keep = 8'hcc;
      8'h43: keep = 8'h53;
      8'hcf: keep = 8'hbc;
      8'hdf: keep = 8'h30;
      default: keep = 8'h00;
    endcase
  endfunction
  task automatic check_all();
    logic [7:0] f, s, g, w, l;
    logic cm, dp, ls, fs;
    logic [3:0] c;
    f = rm[8'h3d];
    s = rm[8'h41];
    g = rm[8'h42];
    w = rm[8'h43];
    l = rm[8'hbf];
    dp = g[3];
    ls = g[2];
    fs = w[6];
    // pin high selects CMOS when the field defers
    cm = (s[7:6] == IF_CMOS) || (!s[6] && pin);
    c = (rm[8'hcf][5:2] > AVG_CODE_MAX) ? AVG_CODE_MAX : rm[8'hcf][5:2];
    if (f[7:6] != 2'b01) `CHK("twos", (f[7:6] == FMT_PIN) ? pin : f[6] == 1'b0, twos_complement_o)
    `CHK("cmos", cm, cmos_mode_o)
    `CHK("lvds", !cm, lvds_mode_o)
    `CHK("readback", rm[0][0], readback_mode_o)
    `CHK("corr", f[5] & dp, dc_correction_on_o)
    `CHK("hold", rm[8'hcf][7] & f[5] & dp, estimate_hold_o)
    `CHK("code", c, loop_averaging_code_o)
    `CHK("tconst", 32'h1 << (20 + c), loop_time_constant_o)
    `CHK("target", MID_CODE + {{8{l[7]}}, l[7:4]}, correction_target_o)
    `CHK("word", {rm[8'h3f], rm[8'h40][7:4]}, user_test_word_o)
    `CHK("pattern", (tps == PATTERN_USER) & dp, user_pattern_active_o)
    `CHK("dpath", dp, digital_path_enable_o)
    `CHK("drive", cm ? s[5:4] : 2'b00, parallel_clock_drive_o)
    `CHK("rise", s[3] ? s[2:1] : EDGE_DEFAULT, rise_shift_code_o)
    `CHK("fall", s[0] ? g[7:6] : EDGE_DEFAULT, fall_shift_code_o)
    `CHK("conv", ls | fs, converter_off_o)
    `CHK("ref", fs, reference_off_o)
    `CHK("drv", ls | fs | w[4], output_driver_off_o)
    `CHK("swing", w[1:0] == BOTH_ON, swing_control_on_o)
    `CHK("hf", rm[8'h4a][0], high_freq_tuning_bit_o)
    `CHK("slow", rm[8'hdf][5:4] == BOTH_ON, slow_rate_mode_o)
    `CHK("strength", rm[8'h26][0], double_data_strength_o)
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == ADDR_POWER) ? {d[7:2], {2{d[0]}}} : d;
    u_cfg_controller_model.write_reg(a, v);
    if (a == ADDR_MODE_CTRL && v[SOFT_RESET_BIT])
      foreach (rm[i]) rm[i] = 8'h00;
    else if (!rm[0][0] || a == ADDR_MODE_CTRL)
      rm[a] = v & keep(a);
    #1;
    check_all();
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] d;
    bit ok;
    u_cfg_controller_model.read_reg(a, d, ok);
    if (!ok)
    begin
      mismatches++;
      results();
    end
    `CHK("rdata", (a == 8'h00) ? 8'h00 : rm[a], d)
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    results();
  end
  initial
  begin
    foreach (rm[i]) rm[i] = 8'h00;
    resetn_i = 1'b0;
    pin = 1'b0;
    tps = 3'b000;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1;
    check_all();
    foreach (al[i]) wr(al[i], 8'h00);
    $display("test reset done");
    for (int i = 0; i < 160; i++)
    begin
      @(posedge clk_i);
      tps <= 3'($random(seed));
      if (i == 80)
        pin <= 1'b1;
      if (i == 80)
        repeat (3) @(posedge clk_i);
      wr(al[$unsigned($random(seed)) % 12], 8'($random(seed)));
    end
    // boundaries of the loop code and pedestal
    foreach (al[i]) wr(8'hcf, 8'h2c + 8'(i << 4));
    wr(8'hbf, 8'h70);
    wr(8'hbf, 8'h80);
    $display("test random done");
    wr(ADDR_MODE_CTRL, 8'h01);
    foreach (al[i]) rd(al[i]);
    rd(8'h00);
    wr(8'h3f, ~rm[8'h3f]);
    rd(8'h3f);
    wr(ADDR_MODE_CTRL, 8'h02);
    $display("test readback done");
    results();
  end
endmodule
